// ### pkg/pm_pkg.sv
// shared constants for the power monitor result and alert register block
// assumes one 100 MHz core clock and an internal register access port
package pm_pkg;

  // register pointer offsets
  localparam logic [7:0] ADDR_POWER   = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_CAL     = 8'h05;
  localparam logic [7:0] ADDR_MASK    = 8'h06;

  // alert select and flags field positions
  localparam int unsigned BIT_SHUNT_HIGH  = 15;
  localparam int unsigned BIT_SHUNT_LOW   = 14;
  localparam int unsigned BIT_BUS_HIGH    = 13;
  localparam int unsigned BIT_BUS_LOW     = 12;
  localparam int unsigned BIT_POWER_HIGH  = 11;
  localparam int unsigned BIT_READY_EN    = 10;
  localparam int unsigned BIT_SOURCE_FLAG = 4;
  localparam int unsigned BIT_DONE_FLAG   = 3;
  localparam int unsigned BIT_OVF_FLAG    = 2;
  localparam int unsigned BIT_POLARITY    = 1;
  localparam int unsigned BIT_LATCH       = 0;

  // values after reset and writable bit masks
  localparam logic [15:0] CAL_RESET     = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [15:0] CAL_WR_BITS   = 16'h7FFF;
  localparam logic [15:0] MASK_WR_BITS  = 16'hFC03;

  // current = shunt * cal, scaled down by this shift
  localparam int unsigned CURRENT_SHIFT = 11;
  // power count is this many current steps; bus step in microvolts
  localparam int unsigned POWER_LSB_RATIO = 25;
  localparam int unsigned BUS_LSB_UV      = 1250;
  localparam int unsigned UV_PER_VOLT     = 1000000;
  localparam logic [15:0] POWER_DIVISOR =
    16'(POWER_LSB_RATIO * UV_PER_VOLT / BUS_LSB_UV);
  // cycles of the serial divider, one quotient bit each
  localparam logic [5:0]  DIV_STEPS = 6'h20;

  // result sequencer, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CURR = 5'b00010,
    ST_PWR  = 5'b00100,
    ST_DIV  = 5'b01000,
    ST_DONE = 5'b10000
  } seq_state_t;

endpackage

// ### rtl/pm_power_divider.sv
// serial divider that scales the current by bus product into power counts
// assumes start is a one-cycle pulse and is not repeated while busy
`timescale 1ns/1ps
`default_nettype none
module pm_power_divider (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  output logic             done,
  output logic      [31:0] quotient
);

  logic [15:0] rem;     // partial remainder, always below the divisor
  logic [31:0] shreg;   // dividend bits shifted out, quotient shifted in
  logic [5:0]  cnt;     // steps left
  logic [16:0] trial;   // remainder with next dividend bit
  logic        fits;    // divisor can be taken away
  logic [31:0] held;    // dividend kept for checking

  assign trial = {rem, shreg[31]};
  assign fits  = trial >= {1'b0, pm_pkg::POWER_DIVISOR};

  // one quotient bit per cycle; 32 cycles trades speed for area
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rem   <= 16'h0000;
      shreg <= 32'h0000_0000;
      cnt   <= 6'h00;
      done  <= 1'b0;
      held  <= 32'h0000_0000;
    end
    else if (start)
    begin
      rem   <= 16'h0000;
      shreg <= dividend;
      held  <= dividend;
      cnt   <= pm_pkg::DIV_STEPS;
      done  <= 1'b0;
    end
    else if (cnt != 6'h00)
    begin
      // fixed divisor gives the 25 current steps per power count
      rem   <= fits ? 16'(trial - {1'b0, pm_pkg::POWER_DIVISOR})
                    : trial[15:0];
      shreg <= {shreg[30:0], fits};
      cnt   <= cnt - 6'h01;
      done  <= (cnt == 6'h01);
    end
    else
    begin
      done <= 1'b0;
    end
  end

  assign quotient = shreg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_power_scale: assert property (done |->
    (64'(quotient) * 64'(pm_pkg::POWER_DIVISOR) <= 64'(held)) &&
    (64'(held) < (64'(quotient) + 64'h1) * 64'(pm_pkg::POWER_DIVISOR)))
    else $error("power quotient not scaled by fixed ratio");

endmodule
`default_nettype wire

// ### rtl/pm_limit_compare.sv
// limit comparator: picks the top enabled alert function and compares
// assumes results and limit are stable while eval is evaluated
`timescale 1ns/1ps
`default_nettype none
module pm_limit_compare (
  input  wire logic [4:0]  enables,
  input  wire logic [15:0] shunt,
  input  wire logic [15:0] bus,
  input  wire logic [15:0] power,
  input  wire logic [15:0] limit,
  output logic             hit
);

  // keep only the highest set enable
  function automatic logic [4:0] top_only(input logic [4:0] e);
    logic [4:0] r;
    r = 5'b00000;
    for (int i = 4; i >= 0; i--)
    begin
      if (e[i] && r == 5'b00000)
      begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  logic [4:0] pick;     // one-hot selected function
  logic       sh_over;  // shunt above limit, signed
  logic       sh_under; // shunt below limit, signed
  logic       bs_over;  // bus above limit
  logic       bs_under; // bus below limit
  logic       pw_over;  // power above limit

  assign pick     = top_only(enables);
  assign sh_over  = $signed(shunt) > $signed(limit);
  assign sh_under = $signed(shunt) < $signed(limit);
  assign bs_over  = bus > limit;
  assign bs_under = bus < limit;
  assign pw_over  = power > limit;
  assign hit = (pick[4] & sh_over)
             | (pick[3] & sh_under)
             | (pick[2] & bs_over)
             | (pick[1] & bs_under)
             | (pick[0] & pw_over);

endmodule
`default_nettype wire

// ### rtl/pm_result_alert_regs.sv
// result, calibration and alert select registers of a power monitor
// assumes the serial interface turns host accesses into reg_wr / reg_rd
// pulses, and the converter pulses results_ready once per finished cycle
//
// Notes on behaviour
// - power count equals 25 current steps
// - power is current times bus voltage
// - current is shunt times calibration, at 04h
// - averaged shunt gives averaged current
// - calibration sets resolution, top bit reads zero
// - only highest enabled limit function compares
// - shunt above limit asserts alert
// - shunt below limit asserts alert
// - bus above limit asserts alert
// - bus below limit asserts alert
// - power above limit asserts alert
// - ready enable asserts alert on done flag
// - source flag separates limit from ready alert
// - latched source flag clears only on read
// - current, calibration, mask registers reset zero
// - done flag after math, single-shot clears
// - overflow flag marks arithmetic overflow
// - polarity bit selects alert active level
// - transparent follows fault, latch holds until read
`timescale 1ns/1ps
`default_nettype none
module pm_result_alert_regs (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] shunt_voltage,
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] alert_limit,
  input  wire logic        results_ready,
  input  wire logic        single_shot_mode,
  input  wire logic        config_write,
  output logic             alert_out,
  output logic             alert_oe
);

  // magnitude of a signed 16-bit value
  function automatic logic [15:0] mag16(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  // register state
  logic [15:0] power_result;       // read-only power
  logic [15:0] current_result;     // read-only signed current
  logic [15:0] scale_calibration;  // read/write calibration
  logic [5:0]  alert_enables;      // bits 15..10 of the mask register
  logic        alert_source_flag;  // limit function fired
  logic        conv_done_flag;     // results complete
  logic        math_overflow_flag; // arithmetic overflow
  logic        alert_polarity_sel; // 1 = active high
  logic        alert_latch_sel;    // 1 = latch

  // sequencer and captured inputs
  pm_pkg::seq_state_t state;
  pm_pkg::seq_state_t next_state;
  logic [15:0] shunt_cap;          // shunt sample used for math
  logic [15:0] bus_cap;            // bus sample used for math
  logic        cur_ovf;            // current saturated this cycle

  // access decode
  logic wr_cal;
  logic wr_mask;
  logic rd_mask;
  assign wr_cal  = reg_wr && (reg_addr == pm_pkg::ADDR_CAL);
  assign wr_mask = reg_wr && (reg_addr == pm_pkg::ADDR_MASK);
  assign rd_mask = reg_rd && (reg_addr == pm_pkg::ADDR_MASK);

  // current math: signed shunt times unsigned calibration
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_scaled;
  logic               cur_fits;
  logic [15:0]        next_current;
  assign cur_prod   = 33'($signed(shunt_cap)) *
                      33'($signed({1'b0, scale_calibration}));
  assign cur_scaled = cur_prod >>> pm_pkg::CURRENT_SHIFT;
  assign cur_fits   = (cur_scaled[32:15] == {18{1'b0}}) ||
                      (cur_scaled[32:15] == {18{1'b1}});
  // saturate keeps sign so reverse current stays negative
  assign next_current = cur_fits ? cur_scaled[15:0]
                      : (cur_scaled[32] ? 16'h8000 : 16'h7FFF);

  // power math: magnitude of current times bus, scaled in divider
  logic [31:0] pwr_prod;
  logic        div_done;
  logic [31:0] div_quot;
  logic        pwr_fits;
  logic [15:0] next_power;
  assign pwr_prod   = 32'(mag16(current_result)) * 32'(bus_cap);
  assign pwr_fits   = (div_quot[31:16] == 16'h0000);
  assign next_power = pwr_fits ? div_quot[15:0] : 16'hFFFF;

  pm_power_divider u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (state == pm_pkg::ST_PWR),
    .dividend (pwr_prod),
    .done     (div_done),
    .quotient (div_quot)
  );

  // limit check on the finished results
  logic limit_hit;
  pm_limit_compare u_cmp (
    .enables (alert_enables[5:1]),
    .shunt   (shunt_cap),
    .bus     (bus_cap),
    .power   (next_power),
    .limit   (alert_limit),
    .hit     (limit_hit)
  );

  // next state of the result sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      pm_pkg::ST_IDLE: if (results_ready) next_state = pm_pkg::ST_CURR;
      pm_pkg::ST_CURR: next_state = pm_pkg::ST_PWR;
      pm_pkg::ST_PWR:  next_state = pm_pkg::ST_DIV;
      pm_pkg::ST_DIV:  if (div_done) next_state = pm_pkg::ST_DONE;
      pm_pkg::ST_DONE: next_state = pm_pkg::ST_IDLE;
      default:         next_state = pm_pkg::ST_IDLE;
    endcase
  end

  // flag set and clear terms; set always wins over clear
  logic eval;
  logic any_ovf;
  logic clr_source;
  logic clr_ovf;
  logic clr_done;
  assign eval       = (state == pm_pkg::ST_DONE);
  assign any_ovf    = cur_ovf || !pwr_fits;
  assign clr_source = alert_latch_sel ? rd_mask
                                      : (eval && !limit_hit);
  assign clr_ovf    = alert_latch_sel ? rd_mask
                                      : (eval && !any_ovf);
  assign clr_done   = single_shot_mode &&
                      (config_write || rd_mask);

  // sequencer state and input capture
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= pm_pkg::ST_IDLE;
      shunt_cap <= pm_pkg::RESULT_RESET;
      bus_cap   <= pm_pkg::RESULT_RESET;
    end
    else
    begin
      state <= next_state;
      // a ready pulse while busy is dropped; the next one is taken
      if (state == pm_pkg::ST_IDLE && results_ready)
      begin
        // shunt already holds the averaged value when averaging is on
        shunt_cap <= shunt_voltage;
        bus_cap   <= bus_voltage;
      end
    end
  end

  // result registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      current_result <= pm_pkg::RESULT_RESET;
      power_result   <= pm_pkg::RESULT_RESET;
      cur_ovf        <= 1'b0;
    end
    else
    begin
      if (state == pm_pkg::ST_CURR)
      begin
        current_result <= next_current;
        cur_ovf        <= !cur_fits;
      end
      if (eval)
      begin
        power_result <= next_power;
      end
    end
  end

  // calibration and mask control bits written by the host
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scale_calibration  <= pm_pkg::CAL_RESET;
      alert_enables      <= pm_pkg::MASK_RESET[15:10];
      alert_polarity_sel <= 1'b0;
      alert_latch_sel    <= 1'b0;
    end
    else
    begin
      if (wr_cal)
      begin
        // top bit never stored, so it reads back zero
        scale_calibration <= reg_wdata & pm_pkg::CAL_WR_BITS;
      end
      if (wr_mask)
      begin
        alert_enables      <= reg_wdata[15:10];
        alert_polarity_sel <= reg_wdata[pm_pkg::BIT_POLARITY];
        alert_latch_sel    <= reg_wdata[pm_pkg::BIT_LATCH];
      end
    end
  end

  // hardware flags; writes to their bit positions are ignored
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alert_source_flag  <= 1'b0;
      conv_done_flag     <= 1'b0;
      math_overflow_flag <= 1'b0;
    end
    else
    begin
      alert_source_flag  <= (eval && limit_hit) ||
                            (alert_source_flag && !clr_source);
      conv_done_flag     <= eval || (conv_done_flag && !clr_done);
      math_overflow_flag <= (eval && any_ovf) ||
                            (math_overflow_flag && !clr_ovf);
    end
  end

  // alert pin: limit flag or ready flag when that is enabled
  logic alert_active;
  assign alert_active = alert_source_flag ||
                        (alert_enables[0] && conv_done_flag);

  // open collector: active-low pulls when active, active-high releases
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alert_oe <= 1'b0;
    end
    else
    begin
      alert_oe <= alert_polarity_sel ? !alert_active
                                     : alert_active;
    end
  end
  assign alert_out = 1'b0;

  // read data mux, registered on the read strobe
  logic [15:0] mask_view;
  logic [15:0] rd_value;
  assign mask_view = {alert_enables, 5'b00000, alert_source_flag,
                      conv_done_flag, math_overflow_flag,
                      alert_polarity_sel, alert_latch_sel};
  assign rd_value =
    (reg_addr == pm_pkg::ADDR_POWER)   ? power_result :
    (reg_addr == pm_pkg::ADDR_CURRENT) ? current_result :
    (reg_addr == pm_pkg::ADDR_CAL)     ? scale_calibration :
    (reg_addr == pm_pkg::ADDR_MASK)    ? mask_view : 16'h0000;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      // flags read as they stood before the read clears them
      reg_rdata <= rd_value;
    end
  end

  // cycles spent in the divide state, read by the sequence check only;
  // counting here keeps the long wait cheap for the property tools
  logic [5:0] div_len;             // edges seen in the divide state
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_len <= 6'h00;
    end
    else if (state == pm_pkg::ST_DIV)
    begin
      div_len <= div_len + 6'h01;
    end
    else
    begin
      div_len <= 6'h00;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_start;
    state == pm_pkg::ST_IDLE && results_ready;
  endsequence
  // divide state entered once and held for all quotient steps
  sequence s_math;
    state == pm_pkg::ST_CURR ##1 state == pm_pkg::ST_PWR
      ##1 state == pm_pkg::ST_DIV
      ##32 (state == pm_pkg::ST_DIV && div_len == pm_pkg::DIV_STEPS);
  endsequence

  chk_cal_top_zero: assert property (!scale_calibration[15])
    else $error("calibration top bit set");

  chk_current_math: assert property (
    state == pm_pkg::ST_CURR && cur_fits |=>
      $signed(current_result) ==
      $signed($past(cur_prod) >>> pm_pkg::CURRENT_SHIFT))
    else $error("current not shunt times calibration");

  chk_done_sequence: assert property (
    s_start |=> s_math ##1 eval ##1 conv_done_flag)
    else $error("done flag not after full math sequence");

  chk_done_cause: assert property ($rose(conv_done_flag) |->
    $past(eval))
    else $error("done flag set without finished math");

  chk_single_clear: assert property (
    clr_done && !eval |=> !conv_done_flag)
    else $error("single-shot done flag not cleared");

  chk_latch_hold: assert property (
    alert_latch_sel && alert_source_flag && !rd_mask |=>
      alert_source_flag)
    else $error("latched source flag dropped without read");

  chk_transp_follow: assert property (
    !alert_latch_sel && eval |=> alert_source_flag == $past(limit_hit))
    else $error("transparent flag does not follow fault");

  chk_ready_alert: assert property (
    alert_enables[0] && $rose(conv_done_flag) |->
      alert_active ##1 alert_oe != alert_polarity_sel)
    else $error("ready alert not driven");

  chk_alert_level: assert property (
    $stable(alert_polarity_sel) |->
      alert_oe == ($past(alert_polarity_sel) ^ $past(alert_active)))
    else $error("alert pin level wrong for polarity");

  chk_ovf_flag: assert property (eval && any_ovf |=>
    math_overflow_flag)
    else $error("overflow not flagged");

endmodule
`default_nettype wire

// ### dv/pm_host_model.sv
// host-side model: issues register writes and reads on the access port
// assumes the bench calls its tasks; the strobes change at falling edges
`timescale 1ns/1ps
`default_nettype none
module pm_host_model (
  input  wire logic        core_clk,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // idle port at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write, strobe held across exactly one rising edge
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    // released data is inverted so a stale word cannot pass
    reg_wdata = ~d;
  endtask

  // one read; data taken a full cycle after the strobe edge, it holds
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### dv/power_monitor_result_alert_regs_test.sv
// self-checking bench: random results and alert settings vs a model
// assumes the hand-over latency of 37 cycles from results_ready to flags
`timescale 1ns/1ps
`default_nettype none
module power_monitor_result_alert_regs_test;
  logic        core_clk;          // 100 MHz
  logic        nrst;              // async, active low
  logic [7:0]  reg_addr;          // from host model
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] shunt_voltage;     // converter side, driven here
  logic [15:0] bus_voltage;
  logic [15:0] alert_limit;
  logic        results_ready;
  logic        single_shot_mode;
  logic        config_write;
  logic        alert_out;
  logic        alert_oe;
  int          n_mismatch;
  int          checked;
  logic [15:0] exp_cal;           // model registers
  logic [15:0] exp_mask;
  logic [15:0] exp_cur;
  logic [15:0] exp_pwr;
  bit          f_src;             // model flags
  bit          f_done;
  bit          f_ovf;
  logic [15:0] rv;
  int          rnd;

  pm_result_alert_regs pm_result_alert_regs_inst (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shunt_voltage(shunt_voltage),
    .bus_voltage(bus_voltage), .alert_limit(alert_limit),
    .results_ready(results_ready), .single_shot_mode(single_shot_mode),
    .config_write(config_write), .alert_out(alert_out),
    .alert_oe(alert_oe)
  );

  pm_host_model pm_host_model_inst (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // free-running clock
  always #5 core_clk = ~core_clk;

  // register word comparison
  task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // pin level comparison
  task automatic chk_pin(input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one result sequence as the rules describe it
  task automatic model_seq();
    longint p;
    int     c;
    int     pw;
    int     sh;
    int     lim;
    bit     hit;
    bit     ov;
    p   = longint'($signed(shunt_voltage)) * longint'(exp_cal);
    p   = p >>> 11;
    ov  = (p > 32767) || (p < -32768);
    c   = (p > 32767) ? 32767 : (p < -32768) ? -32768 : int'(p);
    pw  = ((c < 0) ? -c : c) * int'(bus_voltage) / 20000;
    // saturation of the power count also marks overflow
    if (pw > 65535)
    begin
      pw = 65535;
      ov = 1'b1;
    end
    sh  = int'($signed(shunt_voltage));
    lim = int'($signed(alert_limit));
    // highest enabled limit function wins
    if (exp_mask[15])
      hit = sh > lim;
    else if (exp_mask[14])
      hit = sh < lim;
    else if (exp_mask[13])
      hit = bus_voltage > alert_limit;
    else if (exp_mask[12])
      hit = bus_voltage < alert_limit;
    else if (exp_mask[11])
      hit = pw > int'(alert_limit);
    else
      hit = 1'b0;
    f_src   = hit | (exp_mask[0] & f_src);
    f_ovf   = ov | (exp_mask[0] & f_ovf);
    f_done  = 1'b1;
    exp_cur = 16'(c);
    exp_pwr = 16'(pw);
  endtask

  // all registers and the pin read back idle after reset
  task automatic check_reset_values();
    pm_host_model_inst.read_reg(pm_pkg::ADDR_POWER, rv);
    chk_reg(16'h0000, rv);
    pm_host_model_inst.read_reg(pm_pkg::ADDR_CURRENT, rv);
    chk_reg(16'h0000, rv);
    pm_host_model_inst.read_reg(pm_pkg::ADDR_CAL, rv);
    chk_reg(16'h0000, rv);
    pm_host_model_inst.read_reg(pm_pkg::ADDR_MASK, rv);
    chk_reg(16'h0000, rv);
    chk_pin(1'b0, alert_oe);
    exp_cal  = 16'h0000;
    exp_mask = 16'h0000;
    {f_src, f_done, f_ovf} = 3'b000;
  endtask

  // hang guard, well beyond the length of the run
  initial
  begin
    #500_000;
    n_mismatch++;
    final_report();
  end

  // main sequence
  initial
  begin
    core_clk         = 1'b0;
    nrst             = 1'b0;
    shunt_voltage    = 16'h0000;
    bus_voltage      = 16'h0000;
    alert_limit      = 16'h0000;
    results_ready    = 1'b0;
    single_shot_mode = 1'b0;
    config_write     = 1'b0;
    n_mismatch       = 0;
    checked          = 0;
    rnd              = $urandom(38547);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    check_reset_values();
    // unmapped place and read-only results ignore the host
    pm_host_model_inst.read_reg(8'h1F, rv);
    chk_reg(16'h0000, rv);
    pm_host_model_inst.write_reg(pm_pkg::ADDR_CURRENT, 16'h1234);
    pm_host_model_inst.read_reg(pm_pkg::ADDR_CURRENT, rv);
    chk_reg(16'h0000, rv);
    for (int i = 0; i < 60; i++)
    begin
      // nonzero calibration before relying on results, except rarely
      exp_cal = 16'($urandom) & pm_pkg::CAL_WR_BITS;
      if (i % 8 == 0)
        exp_cal = 16'h0000;
      pm_host_model_inst.write_reg(pm_pkg::ADDR_CAL, exp_cal | 16'h8000);
      exp_mask = 16'($urandom);
      pm_host_model_inst.write_reg(pm_pkg::ADDR_MASK, exp_mask);
      exp_mask = exp_mask & pm_pkg::MASK_WR_BITS;
      pm_host_model_inst.read_reg(pm_pkg::ADDR_CAL, rv);
      chk_reg(exp_cal, rv);
      // new conversion results, then the math sequence
      @(negedge core_clk);
      shunt_voltage    = 16'($urandom);
      bus_voltage      = 16'($urandom) & 16'h7FFF;
      alert_limit      = 16'($urandom);
      single_shot_mode = 1'($urandom);
      results_ready    = 1'b1;
      @(negedge core_clk);
      results_ready    = 1'b0;
      repeat (40) @(negedge core_clk);
      model_seq();
      pm_host_model_inst.write_reg(pm_pkg::ADDR_POWER, 16'($urandom));
      pm_host_model_inst.read_reg(pm_pkg::ADDR_CURRENT, rv);
      chk_reg(exp_cur, rv);
      pm_host_model_inst.read_reg(pm_pkg::ADDR_POWER, rv);
      chk_reg(exp_pwr, rv);
      chk_pin(exp_mask[1] ^ (f_src | (exp_mask[10] & f_done)),
              alert_oe);
      chk_pin(1'b0, alert_out);
      // a configuration write clears the done flag in single-shot only
      if (i % 2 == 1)
      begin
        @(negedge core_clk);
        config_write = 1'b1;
        @(negedge core_clk);
        config_write = 1'b0;
        if (single_shot_mode)
          f_done = 1'b0;
      end
      // some sequences leave the flags unread to see them persist
      if (i % 3 != 1)
      begin
        pm_host_model_inst.read_reg(pm_pkg::ADDR_MASK, rv);
        chk_reg({exp_mask[15:10], 5'h00, f_src, f_done, f_ovf,
                 exp_mask[1:0]}, rv);
        if (exp_mask[0])
          {f_src, f_ovf} = 2'b00;
        if (single_shot_mode)
          f_done = 1'b0;
      end
    end
    // second reset after the last sequence
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    check_reset_values();
    final_report();
  end
endmodule
`default_nettype wire
